/* File: rtl/cpu_freq_pkg.sv */
// Types shared by the frequency select and recovery controller.
// Assumes nothing of its surroundings.
package cpu_freq_pkg;

   // ----------------------------------------------------------------------
   // Watchdog states.
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      WD_IDLE  = 4'h1,
      WD_ARMED = 4'h2,
      WD_COUNT = 4'h4,
      WD_FIRED = 4'h8
   } wd_state_t;

   typedef logic [11:0] tenths_t;

endpackage : cpu_freq_pkg

/* File: rtl/cpu_freq_select_recovery.sv */
// Frequency select, programmable frequency and watchdog recovery control.
// Assumes a byte-wide control port on its own clock from a bus engine,
// strap pins that are asynchronous, and a PLL that takes code or N/M.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_freq_select_recovery_regs.svh"
module cpu_freq_select_recovery
   import cpu_freq_pkg::*;
#(
   parameter int unsigned SHORT_TICK_CYCLES = `WD_SHORT_MS * `CLOCK_KHZ,
   parameter int unsigned LONG_TICK_CYCLES  = `WD_LONG_MS * `CLOCK_KHZ
)(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        smbClock,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   input  wire logic [4:0]  strapFreqCode,
   output logic      [4:0]  freqCode,
   output tenths_t          cpuTenths,
   output tenths_t          midTenths,
   output tenths_t          pciTenths,
   output logic             progMode,
   output logic      [7:0]  pllNumerator,
   output logic      [6:0]  pllDenominator,
   output logic      [22:0] pllGear,
   output logic             freqLoad,
   output logic             systemReset,
   output logic             recoveryActive,
   output logic             watchdogExpiredFlag
);

   // ----------------------------------------------------------------------
   // Link domain: control bytes on the bus engine's clock.
   // ----------------------------------------------------------------------
   logic [1:0] linkRst_r;
   logic       linkReset;
   logic [7:0] selByte_r, wdByte_r, recN_r, recM_r, cpuN_r, progByte_r;
   logic [1:0] rstCtl_r, vendor_r;
   logic       wrToggle_r;
   logic [7:0] wrAddr_r, wrData_r;
   logic [1:0] statMeta_r, statSync_r;

   // Reset reaches the link domain through two flops.
   always_ff @(posedge smbClock) begin
      linkRst_r <= {linkRst_r[0], reset};
   end
   assign linkReset = linkRst_r[1];

   // Byte writes; the spare byte and byte 16 ignore writes.
   always_ff @(posedge smbClock) begin
      if (linkReset) begin
         selByte_r  <= `RST_BYTE;
         wdByte_r   <= `RST_BYTE;
         recN_r     <= `RST_BYTE;
         recM_r     <= `RST_BYTE;
         cpuN_r     <= `RST_BYTE;
         progByte_r <= `RST_BYTE;
         rstCtl_r   <= 2'h0;
         vendor_r   <= `RST_VENDOR;
      end else if (regWrite) begin
         unique case (regAddr)
            `OFS_SEL:    selByte_r  <= regWdata;
            `OFS_WDOG:   wdByte_r   <= regWdata;
            `OFS_RSTCTL: rstCtl_r   <= regWdata[1:0];
            `OFS_REC_N:  recN_r     <= regWdata;
            `OFS_REC_M:  recM_r     <= regWdata;
            `OFS_CPU_N:  cpuN_r     <= regWdata;
            `OFS_PROG:   progByte_r <= regWdata;
            `OFS_VENDOR: vendor_r   <= regWdata[1:0];
            default: ;
         endcase
      end
   end

   // Every write flips a toggle; address and data hold until the next one.
   always_ff @(posedge smbClock) begin
      if (linkReset) begin
         wrToggle_r <= 1'b0;
         wrAddr_r   <= 8'h00;
         wrData_r   <= 8'h00;
      end else if (regWrite) begin
         wrToggle_r <= ~wrToggle_r;
         wrAddr_r   <= regAddr;
         wrData_r   <= regWdata;
      end
   end

   // Status levels from the core cross by two flops each.
   always_ff @(posedge smbClock) begin
      statMeta_r <= {recoveryActive, watchdogExpiredFlag};
      statSync_r <= statMeta_r;
   end

   // Read data follow the address one link cycle later.
   always_ff @(posedge smbClock) begin
      if (linkReset) begin
         regRdata <= 8'h00;
      end else begin
         unique case (regAddr)
            `OFS_SEL:    regRdata <= selByte_r;
            `OFS_WDOG:   regRdata <= {wdByte_r[7:6], statSync_r[0], wdByte_r[4:0]};
            `OFS_RSTCTL: regRdata <= {statSync_r[1], 5'h00, rstCtl_r};
            `OFS_REC_N:  regRdata <= recN_r;
            `OFS_REC_M:  regRdata <= recM_r;
            `OFS_CPU_N:  regRdata <= cpuN_r;
            `OFS_PROG:   regRdata <= progByte_r;
            `OFS_VENDOR: regRdata <= {6'h00, vendor_r};
            default:     regRdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Core domain: write event crossing and strap capture.
   // ----------------------------------------------------------------------
   logic [3:0] wrSync_r;
   logic       wrEdge, wrLate;
   logic [4:0] strapMeta_r, strapSync_r, strapLatch_r;
   logic [1:0] settle_r;
   logic       latched_r;

   // Toggle synchroniser; the link bytes are stable when its edge arrives.
   always_ff @(posedge clock) begin
      if (reset) begin
         wrSync_r <= 4'h0;
      end else begin
         wrSync_r <= {wrSync_r[2:0], wrToggle_r};
      end
   end
   assign wrEdge = wrSync_r[2] ^ wrSync_r[1];
   assign wrLate = wrSync_r[3] ^ wrSync_r[2]; // Shadow holds the byte by now.

   // Strap pins are caught once, a few cycles after reset release.
   always_ff @(posedge clock) begin
      strapMeta_r <= strapFreqCode;
      strapSync_r <= strapMeta_r;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         settle_r     <= 2'h0;
         latched_r    <= 1'b0;
         strapLatch_r <= 5'h00;
      end else begin
         settle_r <= {settle_r[0], 1'b1};
         if (settle_r[1] && !latched_r) begin
            latched_r    <= 1'b1;
            strapLatch_r <= strapSync_r;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Core shadow of the control bytes, taken on each write edge.
   // ----------------------------------------------------------------------
   logic [7:0] cSel_r, cWd_r, cRecN_r, cRecM_r, cCpuN_r, cProg_r;
   logic [1:0] cRst_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         cSel_r  <= `RST_BYTE;
         cWd_r   <= `RST_BYTE;
         cRecN_r <= `RST_BYTE;
         cRecM_r <= `RST_BYTE;
         cCpuN_r <= `RST_BYTE;
         cProg_r <= `RST_BYTE;
         cRst_r  <= 2'h0;
      end else if (wrEdge) begin
         cSel_r  <= selByte_r;
         cWd_r   <= wdByte_r;
         cRecN_r <= recN_r;
         cRecM_r <= recM_r;
         cCpuN_r <= cpuN_r;
         cProg_r <= progByte_r;
         cRst_r  <= rstCtl_r;
      end
   end

   // ----------------------------------------------------------------------
   // Source selection.
   // ----------------------------------------------------------------------
   logic       cpuFieldWr, recFieldWr;
   logic [4:0] ratioCode, code_nxt;
   logic       prog_nxt;
   logic [7:0] num_nxt;
   logic [6:0] den_nxt;
   logic       changed, load_nxt;

   assign cpuFieldWr = wrLate && (wrAddr_r == `OFS_CPU_N || wrAddr_r == `OFS_PROG);
   assign recFieldWr = wrLate && (wrAddr_r == `OFS_REC_N || wrAddr_r == `OFS_REC_M);
   assign ratioCode  = cSel_r[`BIT_OVERRIDE] ? cSel_r[4:0] : strapLatch_r;

   // Recovery outranks programmable mode, which outranks the code table.
   always_comb begin
      prog_nxt = 1'b0;
      num_nxt  = cCpuN_r;
      den_nxt  = cProg_r[6:0];
      code_nxt = ratioCode;
      if (recoveryActive) begin
         if (cRecM_r[`BIT_REC_SEL]) begin
            prog_nxt = 1'b1;
            num_nxt  = cRecN_r;
            den_nxt  = cRecM_r[6:0];
         end else begin
            code_nxt = strapLatch_r;
         end
      end else if (cProg_r[`BIT_PROG_EN]) begin
         prog_nxt = 1'b1;
      end
   end

   assign changed  = {prog_nxt, num_nxt, den_nxt, code_nxt} !=
                     {progMode, pllNumerator, pllDenominator, freqCode};
   assign load_nxt = changed
                   || (cpuFieldWr && cProg_r[`BIT_PROG_EN] && !recoveryActive)
                   || (recFieldWr && recoveryActive && cRecM_r[`BIT_REC_SEL]);

   // PLL settings and the load strobe that tells the PLL to relock.
   always_ff @(posedge clock) begin
      if (reset) begin
         progMode       <= 1'b0;
         pllNumerator   <= 8'h00;
         pllDenominator <= 7'h00;
         freqCode       <= 5'h00;
         freqLoad       <= 1'b0;
         pllGear        <= `GEAR_X100000;
      end else begin
         progMode       <= prog_nxt;
         pllNumerator   <= num_nxt;
         pllDenominator <= den_nxt;
         freqCode       <= code_nxt;
         freqLoad       <= load_nxt && latched_r;
         pllGear        <= `GEAR_X100000;
      end
   end

   freq_code_table table_u (
      .clock     (clock),
      .code      (code_nxt),
      .cpuTenths (cpuTenths),
      .midTenths (midTenths),
      .pciTenths (pciTenths)
   );

   // ----------------------------------------------------------------------
   // Watchdog.
   // ----------------------------------------------------------------------
   wd_state_t   wdState_r;
   logic [26:0] prescale_r;
   logic [26:0] tickLimit;
   logic        tick;
   logic [4:0]  wdCount_r;
   logic        wdEn, expire, flagClear;

   assign wdEn      = cWd_r[`BIT_WATCHDOG_ENABLE];
   assign tickLimit = cWd_r[`BIT_WD_TICK] ? 27'(LONG_TICK_CYCLES - 1)
                                          : 27'(SHORT_TICK_CYCLES - 1);
   assign tick      = (prescale_r == tickLimit);
   assign expire    = (wdState_r == WD_COUNT) && wdEn && tick && (wdCount_r <= 5'h01);
   assign flagClear = wrEdge && (wrAddr_r == `OFS_WDOG) && wrData_r[`BIT_WD_FLAG];

   // Unit tick from the reference clock; it only runs while counting.
   always_ff @(posedge clock) begin
      if (reset || wdState_r != WD_COUNT || tick) begin
         prescale_r <= 27'h0000000;
      end else begin
         prescale_r <= prescale_r + 27'h0000001;
      end
   end

   // The count only starts on a change made outside recovery.
   always_ff @(posedge clock) begin
      if (reset) begin
         wdState_r <= WD_IDLE;
         wdCount_r <= 5'h00;
      end else begin
         unique case (wdState_r)
            WD_IDLE: begin
               wdCount_r <= cWd_r[4:0];
               if (wdEn) wdState_r <= WD_ARMED;
            end
            WD_ARMED: begin
               wdCount_r <= cWd_r[4:0];
               if (!wdEn) wdState_r <= WD_IDLE;
               else if (freqLoad && !recoveryActive) wdState_r <= WD_COUNT;
            end
            WD_COUNT: begin
               if (!wdEn) wdState_r <= WD_IDLE;
               else if (expire) wdState_r <= WD_FIRED;
               else if (tick) wdCount_r <= wdCount_r - 5'h01;
            end
            WD_FIRED: begin
               if (!wdEn) wdState_r <= WD_IDLE;
            end
         endcase
      end
   end

   // Expired flag and recovery; a set in the clear cycle wins.
   always_ff @(posedge clock) begin
      if (reset) begin
         watchdogExpiredFlag <= 1'b0;
         recoveryActive      <= 1'b0;
      end else if (expire) begin
         watchdogExpiredFlag <= 1'b1;
         recoveryActive      <= 1'b1;
      end else if (flagClear) begin
         watchdogExpiredFlag <= 1'b0;
         recoveryActive      <= 1'b0;
      end
   end

   // One-cycle reset pulse; entry into recovery does not count as a change.
   always_ff @(posedge clock) begin
      if (reset) begin
         systemReset <= 1'b0;
      end else begin
         systemReset <= (expire && cRst_r[`BIT_RST_EXP])
                     || (freqLoad && !recoveryActive && cRst_r[`BIT_RST_CHG]);
      end
   end

endmodule : cpu_freq_select_recovery
`default_nettype wire

/* File: rtl/cpu_freq_select_recovery_regs.svh */
// Offsets, field positions, reset values and timing counts of the
// frequency select and recovery controller.
// Assumes a byte-wide control port from an external bus engine.
//
// Contract
// - Decode the 5-bit frequency code into CPU, mid-rate and PCI frequencies.
// - Every code carries the same gear constant; code 11111 gives 133.3 MHz.
// - Programmable mode lets the CPU output span 50 MHz to 248 MHz.
// - Programmable enable resets to 0; then strap or software code applies.
// - Programmable off: override 0 picks strap pins, 1 picks software code.
// - Programmable on: CPU frequency from numerator, denominator and gear constant.
// - Programmable on: override picks the source of gear and output ratio; the code keeps pllGear at GEAR_X100000 in every mode.
// - Numerator 8 bits, denominator 7 bits; writing either starts a load.
// - Expiry switches to recovery; select 0 uses strap, 1 uses recovery fields.
// - Recovery fields set recovery CPU frequency; override sets the ratio.
// - Writing a recovery numerator or denominator starts a recovery load.
// - Watchdog enable 0 stops and reloads; 1 arms countdown after a change.
// - On expiry raise a system reset and activate the recovery frequency; the code raises the reset only when reset-on-expiry enable is 1.
// - Expired flag sets at zero count; write 1 clears, write 0 ignored.
// - Tick select 0 gives 150 ms units, 1 gives 2.5 s units.
// - Reset-on-expiry enable 1 pulses reset on expiry, 0 does not.
// - Reset-on-change enable 1 pulses reset after a change, 0 does not.
`ifndef CPU_FREQ_SELECT_RECOVERY_REGS_SVH
`define CPU_FREQ_SELECT_RECOVERY_REGS_SVH

// ----------------------------------------------------------------------
// Control byte offsets.
// ----------------------------------------------------------------------
`define OFS_SEL          8'h08
`define OFS_WDOG         8'h09
`define OFS_RSTCTL       8'h0A
`define OFS_REC_N        8'h0B
`define OFS_REC_M        8'h0C
`define OFS_CPU_N        8'h0D
`define OFS_PROG         8'h0E
`define OFS_VENDOR       8'h0F
`define OFS_RSVD16       8'h10
`define OFS_SPARE        8'h11

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define BIT_OVERRIDE     7
`define BIT_WATCHDOG_ENABLE        7
`define BIT_WD_TICK      6
`define BIT_WD_FLAG      5
`define BIT_REC_SEL      7
`define BIT_PROG_EN      7
`define BIT_RST_EXP      1
`define BIT_RST_CHG      0
`define BIT_REC_ACTIVE   7

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_VENDOR       2'h3
`define GEAR_X100000     23'h4940E5

// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define CLOCK_KHZ        40000
`define WD_SHORT_MS      150
`define WD_LONG_MS       2500

`endif

/* File: rtl/freq_code_table.sv */
// Frequency selection table: 5-bit code to CPU, mid-rate and PCI
// frequencies in tenths of a MHz, registered.
// Assumes the code comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module freq_code_table
   import cpu_freq_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [4:0] code,
   output tenths_t         cpuTenths,
   output tenths_t         midTenths,
   output tenths_t         pciTenths
);

   logic [35:0] entry;

   // ----------------------------------------------------------------------
   // Lookup, one row per code: CPU, mid-rate, PCI.
   // ----------------------------------------------------------------------
   always_comb begin
      unique case (code)
         5'h00: entry = 36'h3EF29F150;
         5'h01: entry = 36'h3F12A1150;
         5'h02: entry = 36'h4382D0168;
         5'h03: entry = 36'h3F42A3151;
         5'h04: entry = 36'h4742F817C;
         5'h05: entry = 36'h49230C186;
         5'h06: entry = 36'h4B0320190;
         5'h07: entry = 36'h4CE33419A;
         5'h08: entry = 36'h4EC27613B;
         5'h09: entry = 36'h51428A145;
         5'h0A: entry = 36'h53B29E14F;
         5'h0B: entry = 36'h53E29F150;
         5'h0C: entry = 36'h5412A1150;
         5'h0D: entry = 36'h5C82E4172;
         5'h0E: entry = 36'h5F02F817C;
         5'h0F: entry = 36'h61830C186;
         5'h10: entry = 36'h640320190;
         5'h11: entry = 36'h66833419A;
         5'h12: entry = 36'h68A29D14F;
         5'h13: entry = 36'h6A42A8154;
         5'h14: entry = 36'h6D62BC15E;
         5'h15: entry = 36'h7082D0168;
         5'h16: entry = 36'h73A2E4172;
         5'h17: entry = 36'h76C2F817C;
         5'h18: entry = 36'h68429B14E;
         5'h19: entry = 36'h3EA29C14E;
         5'h1A: entry = 36'h53829C14E;
         5'h1B: entry = 36'h7D429C14E;
         5'h1C: entry = 36'h68229A14D;
         5'h1D: entry = 36'h3E829A14D;
         5'h1E: entry = 36'h7D029A14D;
         5'h1F: entry = 36'h53529A14D;
      endcase
   end

   // Registered so the frequency words never glitch between codes.
   always_ff @(posedge clock) begin
      cpuTenths <= entry[35:24];
      midTenths <= entry[23:12];
      pciTenths <= entry[11:0];
   end

endmodule : freq_code_table
`default_nettype wire

/* File: test/cpu_freq_select_recovery_checker.sv */
// Concurrent checks on the frequency select and recovery controller.
// Assumes it is bound into the controller and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cpu_freq_select_recovery_checker
   import cpu_freq_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [4:0]  freqCode,
   input wire tenths_t     cpuTenths,
   input wire tenths_t     midTenths,
   input wire tenths_t     pciTenths,
   input wire logic        progMode,
   input wire logic [7:0]  pllNumerator,
   input wire logic [22:0] pllGear,
   input wire logic        freqLoad,
   input wire logic        systemReset,
   input wire logic        recoveryActive,
   input wire logic        watchdogExpiredFlag
);
   // ------------------------------------------------------------------
   // Core-domain properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // Table words are checked only once the code has settled a cycle.
   gear_const_a: assert property (pllGear == 23'h4940E5)
      else $error("gear constant wrong");
   code_zero_a: assert property (freqCode == 5'h00 && $stable(freqCode)
      |-> cpuTenths == 12'h3EF && midTenths == 12'h29F && pciTenths == 12'h150)
      else $error("code 0 table words wrong");
   code_top_a: assert property (freqCode == 5'h1F && $stable(freqCode)
      |-> cpuTenths == 12'h535 && midTenths == 12'h29A && pciTenths == 12'h14D)
      else $error("code 1F table words wrong");
   load_pulse_a: assert property (freqLoad |=> !freqLoad)
      else $error("load strobe longer than one cycle");
   load_on_n_a: assert property (progMode && $stable(progMode) &&
      $changed(pllNumerator) |-> freqLoad)
      else $error("numerator changed without load");
   reset_pulse_a: assert property (systemReset |=> !systemReset)
      else $error("system reset longer than one cycle");
   expiry_rec_a: assert property ($rose(watchdogExpiredFlag) |-> $rose(recoveryActive))
      else $error("expiry without recovery");
   rec_flag_a: assert property (recoveryActive |-> watchdogExpiredFlag)
      else $error("recovery without expired flag");
   rec_load_a: assert property ($rose(recoveryActive) |-> ##[1:3] freqLoad)
      else $error("recovery did not load");
endmodule : cpu_freq_select_recovery_checker

bind cpu_freq_select_recovery cpu_freq_select_recovery_checker chk (
   .clock(clock), .reset(reset), .freqCode(freqCode),
   .cpuTenths(cpuTenths), .midTenths(midTenths), .pciTenths(pciTenths),
   .progMode(progMode), .pllNumerator(pllNumerator), .pllGear(pllGear),
   .freqLoad(freqLoad), .systemReset(systemReset),
   .recoveryActive(recoveryActive), .watchdogExpiredFlag(watchdogExpiredFlag)
);
`default_nettype wire

/* File: test/smb_host_model.sv */
// Host-side model of the control port: writes and reads control bytes.
// Assumes the controller samples the byte port on a free-running smbClock.
`timescale 1ns/10ps
`default_nettype none
module smb_host_model (
   input  wire logic       smbClock,
   input  wire logic [7:0] regRdata,
   output logic            regWrite,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWdata
);
   // ------------------------------------------------------------------
   // Byte transfers
   // ------------------------------------------------------------------
   // The port idles with the strobe low.
   initial begin
      regWrite = 1'b0;
      regAddr  = 8'h00;
      regWdata = 8'h5A;
   end

   // One-cycle strobe, then a gap so the core copies the byte first.
   // Released data shows the inverse, so a stale byte is never reused.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge smbClock);
      regAddr  = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge smbClock);
      regWrite = 1'b0;
      regWdata = ~d;
      repeat (2) @(negedge smbClock);
   endtask : wr

   // Numerator and denominator back to back limit interim loads.
   task automatic wrNm(input logic [7:0] n, input logic [7:0] m);
      wr(8'h0D, n);
      wr(8'h0E, m);
   endtask : wrNm

   // Read data is valid one link cycle after the address is shown.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge smbClock);
      regAddr = a;
      repeat (2) @(negedge smbClock);
      d = regRdata;
   endtask : rd
endmodule : smb_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the frequency select and recovery controller.
// Assumes the host model drives the byte port on a 64 ns link clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import cpu_freq_pkg::*;

   logic        clock, reset, smbClock, regWrite, progMode, freqLoad;
   logic        systemReset, recoveryActive, watchdogExpiredFlag;
   logic [7:0]  regAddr, regWdata, regRdata, pllNumerator;
   logic [6:0]  pllDenominator;
   logic [22:0] pllGear;
   logic [4:0]  strapFreqCode, freqCode;
   tenths_t     cpuTenths, midTenths, pciTenths;
   int          nErrors, numChecks, nRst, base;
   logic [4:0]  swCode [3] = '{5'h1F, 5'h12, 5'h00};
   logic [35:0] swExp  [3] = '{36'h53529A14D, 36'h68A29D14F, 36'h3EF29F150};
   logic [7:0]  rsv    [3] = '{8'h10, 8'h11, 8'h20};

   // ------------------------------------------------------------------
   // Design, host and clocks
   // ------------------------------------------------------------------
   // Short ticks keep the watchdog runs to a few dozen cycles.
   cpu_freq_select_recovery #(.SHORT_TICK_CYCLES(8), .LONG_TICK_CYCLES(20)) uut (
      .clock(clock), .reset(reset), .smbClock(smbClock), .regWrite(regWrite),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .strapFreqCode(strapFreqCode), .freqCode(freqCode), .cpuTenths(cpuTenths),
      .midTenths(midTenths), .pciTenths(pciTenths), .progMode(progMode),
      .pllNumerator(pllNumerator), .pllDenominator(pllDenominator),
      .pllGear(pllGear), .freqLoad(freqLoad), .systemReset(systemReset),
      .recoveryActive(recoveryActive), .watchdogExpiredFlag(watchdogExpiredFlag)
   );
   smb_host_model host (.smbClock(smbClock), .regRdata(regRdata),
      .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata));

   // Two unrelated clocks: 25 ns core, 64 ns link.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      smbClock = 1'b0;
      #7;
      forever #32 smbClock = ~smbClock;
   end

   // Reset pulses are counted so a missing or extra one shows up.
   always @(posedge clock) begin
      if (systemReset === 1'b1) begin
         nRst <= nRst + 1;
      end
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic endOfTest();
      if (nErrors == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : endOfTest

   // The byte crosses into the core in a few clocks; let it land.
   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      repeat (8) @(negedge clock);
   endtask : wrReg

   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      check(d, e);
   endtask : rdChk

   // Arm, change the numerator, then time the expiry from the load.
   task automatic wdRun(input logic [7:0] wdByte, input logic [7:0] n,
                        input int lo, input int hi);
      int cnt;
      wrReg(8'h09, 8'h20);
      wrReg(8'h09, wdByte);
      cnt = 0;
      fork
         host.wr(8'h0D, n);
         begin
            while (freqLoad !== 1'b1 && cnt < 200) begin
               @(negedge clock);
               cnt++;
            end
            cnt = 0;
            while (watchdogExpiredFlag !== 1'b1 && cnt < 400) begin
               @(negedge clock);
               cnt++;
            end
         end
      join
      check(cnt >= lo && cnt <= hi, 1'b1);
      check(recoveryActive, 1'b1);
      repeat (6) @(negedge clock);
      check({pllNumerator, pllDenominator}, 15'h3311);
   endtask : wdRun

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      nErrors       = 0;
      numChecks     = 0;
      reset         = 1'b1;
      strapFreqCode = 5'h1D;
      repeat (10) @(negedge clock);
      reset = 1'b0;
      repeat (6) @(negedge smbClock);
      // Power-on state: bytes cleared except vendor byte 15 at 03, straps in force.
      for (int a = 8; a < 18; a++) begin
         rdChk(8'(a), (a == 15) ? 8'h03 : 8'h00);
      end
      check(progMode, 1'b0);
      check(freqCode, 5'h1D);
      check({cpuTenths, midTenths, pciTenths}, 36'h3E829A14D);
      check(pllGear, 23'h4940E5);
      // Software codes through the override, then back to the straps.
      for (int i = 0; i < 3; i++) begin
         wrReg(8'h08, {3'b100, swCode[i]});
         check({cpuTenths, midTenths, pciTenths}, swExp[i]);
      end
      wrReg(8'h08, 8'h1F);
      check(freqCode, 5'h1D);
      // Reserved and unmapped bytes ignore writes.
      for (int i = 0; i < 3; i++) begin
         wrReg(rsv[i], 8'hFF);
         rdChk(rsv[i], 8'h00);
      end
      // Programmable mode: N and M drive the PLL, override picks the ratio.
      host.wrNm(8'hA5, 8'hAD);
      repeat (8) @(negedge clock);
      check(progMode, 1'b1);
      check({pllNumerator, pllDenominator}, 15'h52AD);
      check(freqCode, 5'h1D);
      wrReg(8'h08, 8'h85);
      check(freqCode, 5'h05);
      // Watchdog expiry into the recovery numbers, both tick sizes.
      wrReg(8'h0C, 8'h91);
      wrReg(8'h0B, 8'h66);
      wrReg(8'h0A, 8'h00);
      base = nRst;
      wdRun(8'h83, 8'h70, 17, 28);
      check(36'(nRst - base), 36'h0);
      wrReg(8'h0A, 8'h02);
      base = nRst;
      wdRun(8'hC2, 8'h71, 21, 44);
      check(36'(nRst - base), 36'h1);
      wdRun(8'h80, 8'h72, 1, 12);
      rdChk(8'h09, 8'hA0);
      rdChk(8'h0A, 8'h82);
      wrReg(8'h09, 8'h80);
      check(watchdogExpiredFlag, 1'b1);
      wrReg(8'h09, 8'h20);
      check({watchdogExpiredFlag, recoveryActive}, 2'b00);
      check(pllNumerator, 8'h72);
      // A stopped watchdog never fires after a change.
      wrReg(8'h09, 8'h01);
      wrReg(8'h0D, 8'h73);
      repeat (40) @(negedge clock);
      check(watchdogExpiredFlag, 1'b0);
      // Reset pulse after a frequency change.
      wrReg(8'h0A, 8'h01);
      base = nRst;
      wrReg(8'h0D, 8'h74);
      check(36'(nRst - base), 36'h1);
      endOfTest();
   end

   // A hang is cut short well past the expected run length.
   initial begin
      #150us;
      nErrors++;
      endOfTest();
   end
endmodule : tb_top
`default_nettype wire
